/* File: phy_extended_control_register_test.sv */
// Purpose: Self-checking bench for the extended control register
// Assumes: Straps captured within five cycles of reset release
// Notes:   All inputs change on the falling clock edge
`timescale 1ns/1ps
module phy_extended_control_register_test;
    import pxc_pkg::*;

    logic        I_SYS_CLK = 1'b0;
    logic        I_RESETN  = 1'b0;
    logic        I_SW_RESET = 1'b0;
    logic        I_TX_ERR  = 1'b0;
    logic        I_SPEED_100 = 1'b1;
    logic        I_OVR_PROT_WR = 1'b0;
    logic [3:0]  I_TX_NIBBLE = 4'h0;
    logic [4:0]  straps    = 5'h15;
    logic [4:0]  sym_exp [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
        5'h05, 5'h06, 5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19,
        5'h18, 5'h1F};
    pxc_mgmt_t   mgmt;
    pxc_ctrl_t   ctrl;
    logic [15:0] rdata, got;
    logic [4:0]  tx_sym, port_addr;
    logic        nrzi, bypass, unlock, allow;
    int          allow_cnt = 0;
    int          mark;
    int          err_total = 0;
    int          checked = 0;

    always #5 I_SYS_CLK = ~I_SYS_CLK;

    // Count permitted protected writes; scenarios compare against a mark
    always @(posedge I_SYS_CLK)
        if (allow === 1'b1)
            allow_cnt <= allow_cnt + 1;

    pxc_sta_model sta (.i_clk(I_SYS_CLK), .i_rdata(rdata), .o_mgmt(mgmt));

    pxc_ext_ctrl dut
    (
        .I_SYS_CLK                   (I_SYS_CLK),
        .I_RESETN                    (I_RESETN),
        .I_SW_RESET                  (I_SW_RESET),
        .I_MGMT                      (mgmt),
        .O_RDATA                     (rdata),
        .I_PORT_ADDRESS_BIT4_LED_PIN (straps[4]),
        .I_PORT_ADDRESS_BIT3_LED_PIN (straps[3]),
        .I_PORT_ADDRESS_BIT2_LED_PIN (straps[2]),
        .I_PORT_ADDRESS_BIT1_LED_PIN (straps[1]),
        .I_PORT_ADDRESS_BIT0_LED_PIN (straps[0]),
        .I_TX_ERR                    (I_TX_ERR),
        .I_TX_NIBBLE                 (I_TX_NIBBLE),
        .I_TX_NORMAL_SYM             (5'h1E),
        .I_SPEED_100                 (I_SPEED_100),
        .I_OVR_PROT_WR               (I_OVR_PROT_WR),
        .O_TX_SYM                    (tx_sym),
        .O_NRZI_SEL                  (nrzi),
        .O_SCR_BYPASS                (bypass),
        .O_FORCE_UNLOCK              (unlock),
        .O_OVR_ALLOW                 (allow),
        .O_PORT_ADDR                 (port_addr),
        .O_CTRL                      (ctrl)
    );

    // --------------------------------------------------------------
    // Compare and report
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge I_SYS_CLK);
        I_RESETN = 1'b1;
        repeat (5) @(negedge I_SYS_CLK);
        // Defaults: straps latched, NRZI on, reserved read zero
        sta.rd(ADDR_EXT_CTRL, got);
        chk(got, 16'h0548);
        chk(16'(port_addr), 16'h0015);
        chk(16'(nrzi), 16'h0001);
        // Every control bit except override enable set, reserved bits stripped by the model
        sta.wr(ADDR_EXT_CTRL, 16'h7FFF);
        sta.rd(ADDR_EXT_CTRL, got);
        chk(got, 16'h056D);
        chk(16'(unlock), 16'h0001);
        chk(16'(bypass), 16'h0001);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge I_SYS_CLK);
            I_TX_ERR    = 1'b1;
            I_TX_NIBBLE = 4'(i);
            #1 chk(16'(tx_sym), 16'(sym_exp[i]));
        end
        @(negedge I_SYS_CLK);
        I_TX_ERR    = 1'b0;
        I_SPEED_100 = 1'b0;
        #1 chk(16'(tx_sym), 16'h001E);
        chk(16'(nrzi), 16'h0000);
        @(negedge I_SYS_CLK);
        I_SPEED_100 = 1'b1;
        #1 chk(16'(nrzi), 16'h0001);
        // Back to NRZ, scrambler on, test mode off
        sta.gap = 2;
        sta.wr(ADDR_EXT_CTRL, 16'h0000);
        sta.gap = 0;
        chk(16'(nrzi), 16'h0000);
        chk(16'(bypass), 16'h0000);
        chk(16'(unlock), 16'h0000);
        // Arm, then one protected write elsewhere
        sta.wr(ADDR_EXT_CTRL, 16'h8008);
        chk(16'(ctrl.ovr_en), 16'h0001);
        I_OVR_PROT_WR = 1'b1;
        mark = allow_cnt;
        sta.wr(5'h11, 16'h0001);
        chk(16'(allow_cnt - mark), 16'h0001);
        chk(16'(ctrl.ovr_en), 16'h0000);
        // Second write without re-arming must not get through
        mark = allow_cnt;
        sta.wr(5'h11, 16'h0001);
        chk(16'(allow_cnt - mark), 16'h0000);
        sta.wr(ADDR_EXT_CTRL, 16'h8000);
        mark = allow_cnt;
        sta.wr(5'h12, 16'h0002);
        chk(16'(allow_cnt - mark), 16'h0001);
        I_OVR_PROT_WR = 1'b0;
        sta.rd(ADDR_EXT_CTRL, got);
        chk(got, 16'h0540);
        // Software reset with straps moved: address kept
        straps     = 5'h0A;
        I_SW_RESET = 1'b1;
        @(negedge I_SYS_CLK);
        I_SW_RESET = 1'b0;
        sta.rd(ADDR_EXT_CTRL, got);
        chk(got, 16'h0548);
        chk(16'(port_addr), 16'h0015);
        // Hardware reset relatches the moved straps
        @(negedge I_SYS_CLK);
        I_RESETN = 1'b0;
        repeat (2) @(negedge I_SYS_CLK);
        I_RESETN = 1'b1;
        repeat (5) @(negedge I_SYS_CLK);
        chk(16'(port_addr), 16'h000A);
        sta.rd(ADDR_EXT_CTRL, got);
        chk(got, 16'h0288);
        finish_test();
    end
endmodule : phy_extended_control_register_test

/* File: pxc_ext_ctrl.sv */
// Purpose: Extended control register of a 10/100 PHY management block
// Assumes: Management frames already decoded into single-cycle strobes
// Notes:   Port address pins sampled once after hardware reset release
`timescale 1ns/1ps

// Function
// - Armed override lets next write change protected bits
// - Override enable self-clears after next write to another register
// - Reserved bits 14:11, 4, 1 read zero
// - Port address latched from LED pins at reset
// - Software reset keeps the port address
// - Scrambler test bit forces descrambler lock loss
// - Bit 3 selects NRZ or NRZI at 100 Mb/s (NRZ at 10 Mb/s), default NRZI
// - Invalid-code bit plus transmit error maps nibbles
// - Scrambler disable bypasses scrambling and descrambling
module pxc_ext_ctrl
(
    // Clock and resets
    input  wire logic               I_SYS_CLK,
    input  wire logic               I_RESETN,
    input  wire logic               I_SW_RESET,
    // Management access
    input  wire pxc_pkg::pxc_mgmt_t I_MGMT,
    output logic             [15:0] O_RDATA,
    // Port address straps on the LED pins
    input  wire logic               I_PORT_ADDRESS_BIT4_LED_PIN,
    input  wire logic               I_PORT_ADDRESS_BIT3_LED_PIN,
    input  wire logic               I_PORT_ADDRESS_BIT2_LED_PIN,
    input  wire logic               I_PORT_ADDRESS_BIT1_LED_PIN,
    input  wire logic               I_PORT_ADDRESS_BIT0_LED_PIN,
    // Transmit datapath hooks
    input  wire logic               I_TX_ERR,
    input  wire logic         [3:0] I_TX_NIBBLE,
    input  wire logic         [4:0] I_TX_NORMAL_SYM,
    input  wire logic               I_SPEED_100,
    input  wire logic               I_OVR_PROT_WR,
    // Outputs
    output logic              [4:0] O_TX_SYM,
    output logic                    O_NRZI_SEL,
    output logic                    O_SCR_BYPASS,
    output logic                    O_FORCE_UNLOCK,
    output logic                    O_OVR_ALLOW,
    output logic              [4:0] O_PORT_ADDR,
    output pxc_pkg::pxc_ctrl_t      O_CTRL
);
    import pxc_pkg::*;

    // ---------------------------------------------------------------
    // Strap synchronisers and capture
    // ---------------------------------------------------------------
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [1:0] cap_cnt_r;
    logic [4:0] port_addr_r;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
        end
        else
        begin
            pin_s1_r <= {I_PORT_ADDRESS_BIT4_LED_PIN,
                         I_PORT_ADDRESS_BIT3_LED_PIN,
                         I_PORT_ADDRESS_BIT2_LED_PIN,
                         I_PORT_ADDRESS_BIT1_LED_PIN,
                         I_PORT_ADDRESS_BIT0_LED_PIN};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Wait for the synchroniser to fill before latching the strap
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            cap_cnt_r <= 2'h0;
        else if (cap_cnt_r != 2'h3)
            cap_cnt_r <= cap_cnt_r + 2'h1;
    end

    // Software reset deliberately absent here
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            port_addr_r <= RST_PORT_ADDR;
        else if (cap_cnt_r == 2'h2)
            port_addr_r <= pin_s2_r;
    end

    // ---------------------------------------------------------------
    // Writable control bits
    // ---------------------------------------------------------------
    logic wr_hit;
    logic ovr_en_r;
    logic scr_test_r;
    logic nrzi_r;
    logic inv_code_r;
    logic scr_dis_r;

    assign wr_hit = I_MGMT.wr && (I_MGMT.addr == ADDR_EXT_CTRL);

    // Any management write consumes the arming; a write here with bit 15 set re-arms
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            ovr_en_r <= RST_OVR_EN;
        else if (I_SW_RESET)
            ovr_en_r <= RST_OVR_EN;
        else if (wr_hit)
            ovr_en_r <= I_MGMT.wdata[BIT_OVR_EN];
        else if (I_MGMT.wr)
            ovr_en_r <= 1'b0;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            scr_test_r <= RST_SCR_TEST;
            nrzi_r     <= RST_NRZI;
            inv_code_r <= RST_INV_CODE;
            scr_dis_r  <= RST_SCR_DIS;
        end
        else if (I_SW_RESET)
        begin
            scr_test_r <= RST_SCR_TEST;
            nrzi_r     <= RST_NRZI;
            inv_code_r <= RST_INV_CODE;
            scr_dis_r  <= RST_SCR_DIS;
        end
        else if (wr_hit)
        begin
            // Reserved write data is dropped, not stored
            scr_test_r <= I_MGMT.wdata[BIT_SCR_TEST];
            nrzi_r     <= I_MGMT.wdata[BIT_NRZI];
            inv_code_r <= I_MGMT.wdata[BIT_INV_CODE];
            scr_dis_r  <= I_MGMT.wdata[BIT_SCR_DIS];
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    logic [15:0] rd_word;

    always_comb
    begin
        rd_word = 16'h0000;
        rd_word[BIT_OVR_EN] = ovr_en_r;
        rd_word[BIT_ADDR_HI:BIT_ADDR_LO] = port_addr_r;
        rd_word[BIT_SCR_TEST] = scr_test_r;
        rd_word[BIT_NRZI] = nrzi_r;
        rd_word[BIT_INV_CODE] = inv_code_r;
        rd_word[BIT_SCR_DIS] = scr_dis_r;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_RDATA <= 16'h0000;
        else if (I_MGMT.rd && (I_MGMT.addr == ADDR_EXT_CTRL))
            O_RDATA <= rd_word & RD_MASK;
    end

    // ---------------------------------------------------------------
    // Datapath controls
    // ---------------------------------------------------------------
    // Protected-bit writes elsewhere are gated by this level
    assign O_OVR_ALLOW    = ovr_en_r && I_MGMT.wr && I_OVR_PROT_WR;
    assign O_NRZI_SEL     = I_SPEED_100 && nrzi_r;
    assign O_SCR_BYPASS   = scr_dis_r;
    assign O_FORCE_UNLOCK = scr_test_r;
    assign O_PORT_ADDR    = port_addr_r;
    assign O_CTRL         = '{scr_test: scr_test_r, nrzi: nrzi_r,
                              inv_code: inv_code_r, scr_dis: scr_dis_r,
                              ovr_en: ovr_en_r};

    pxc_inv_map u_inv_map
    (
        .i_enable     (inv_code_r && I_TX_ERR),
        .i_nibble     (I_TX_NIBBLE),
        .i_normal_sym (I_TX_NORMAL_SYM),
        .o_sym        (O_TX_SYM)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_self_clear;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (ovr_en_r && I_MGMT.wr && !wr_hit) |=> !ovr_en_r;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("override enable did not self-clear");

    property p_unarmed;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (I_MGMT.wr && !wr_hit) |=> !O_OVR_ALLOW;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("protected write allowed while unarmed");

    property p_armed;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (wr_hit && I_MGMT.wdata[BIT_OVR_EN] && !I_SW_RESET)
            ##1 (I_MGMT.wr && I_OVR_PROT_WR) |-> O_OVR_ALLOW;
    endproperty
    a_armed: assert property (p_armed)
        else $error("armed write not allowed");

    property p_rsv_zero;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_RDATA & ~RD_MASK) == 16'h0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bit read nonzero");

    property p_addr_stable;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (cap_cnt_r == 2'h3) |=> $stable(port_addr_r);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("port address changed after capture");

    property p_addr_cap;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (cap_cnt_r == 2'h2) |=> (port_addr_r == $past(pin_s2_r));
    endproperty
    a_addr_cap: assert property (p_addr_cap)
        else $error("port address not captured from pins");

    property p_nrzi;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (wr_hit && !I_SW_RESET) |=>
            (O_NRZI_SEL == (I_SPEED_100 && $past(I_MGMT.wdata[BIT_NRZI])));
    endproperty
    a_nrzi: assert property (p_nrzi)
        else $error("line encoding select wrong");

    property p_bypass;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (wr_hit && !I_SW_RESET) |=>
            (O_SCR_BYPASS == $past(I_MGMT.wdata[BIT_SCR_DIS]))
            && (O_FORCE_UNLOCK == $past(I_MGMT.wdata[BIT_SCR_TEST]));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("scrambler control wrong");

    property p_inv;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (inv_code_r && I_TX_ERR && I_TX_NIBBLE == 4'hF) |-> O_TX_SYM == 5'h1F;
    endproperty
    a_inv: assert property (p_inv)
        else $error("invalid-code mapping wrong");

    c_arm_then_write: cover property (@(posedge I_SYS_CLK)
        wr_hit && I_MGMT.wdata[BIT_OVR_EN] ##[1:4] O_OVR_ALLOW);
    c_inv_code: cover property (@(posedge I_SYS_CLK)
        inv_code_r && I_TX_ERR);
    c_read: cover property (@(posedge I_SYS_CLK)
        I_MGMT.rd && I_MGMT.addr == ADDR_EXT_CTRL);
endmodule : pxc_ext_ctrl

/* File: pxc_inv_map.sv */
// Purpose: Nibble to five-bit symbol translation for invalid-code test
// Assumes: Normal 4B/5B symbol is produced elsewhere
// Notes:   Purely combinational
`timescale 1ns/1ps
module pxc_inv_map
(
    // Inputs
    input  wire logic       i_enable,
    input  wire logic [3:0] i_nibble,
    input  wire logic [4:0] i_normal_sym,
    // Outputs
    output logic      [4:0] o_sym
);
    import pxc_pkg::*;

    function automatic logic [4:0] test_sym(input logic [3:0] n);
        case (n)
            4'h8:    test_sym = 5'h00;
            4'h9:    test_sym = 5'h0D;
            4'hA:    test_sym = 5'h0C;
            4'hB:    test_sym = 5'h11;
            4'hC:    test_sym = 5'h10;
            4'hD:    test_sym = 5'h19;
            4'hE:    test_sym = 5'h18;
            4'hF:    test_sym = 5'h1F;
            default: test_sym = {1'b0, n};
        endcase
    endfunction : test_sym

    always_comb
    begin
        o_sym = i_enable ? test_sym(i_nibble) : i_normal_sym;
    end
endmodule : pxc_inv_map

/* File: pxc_pkg.sv */
// Purpose: Constants and types for the extended control register block
// Assumes: 16-bit management register at address 0x10
// Notes:   Shared by the register bank and its invalid-code mapper
package pxc_pkg;
    localparam logic [4:0]  ADDR_EXT_CTRL    = 5'h10;
    localparam int          BIT_OVR_EN       = 15;
    localparam int          BIT_ADDR_HI      = 10;
    localparam int          BIT_ADDR_LO      = 6;
    localparam int          BIT_SCR_TEST     = 5;
    localparam int          BIT_NRZI         = 3;
    localparam int          BIT_INV_CODE     = 2;
    localparam int          BIT_SCR_DIS      = 0;
    localparam logic [15:0] RD_MASK          = 16'h87ED;
    localparam logic        RST_OVR_EN       = 1'b0;
    localparam logic        RST_SCR_TEST     = 1'b0;
    localparam logic        RST_NRZI         = 1'b1;
    localparam logic        RST_INV_CODE     = 1'b0;
    localparam logic        RST_SCR_DIS      = 1'b0;
    localparam logic [4:0]  RST_PORT_ADDR    = 5'h00;

    // Management access as seen by the register bank
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pxc_mgmt_t;

    // Controls steering the PCS / PMD datapath
    typedef struct packed {
        logic scr_test;
        logic nrzi;
        logic inv_code;
        logic scr_dis;
        logic ovr_en;
    } pxc_ctrl_t;
endpackage : pxc_pkg

/* File: pxc_sta_model.sv */
// Purpose: Station management controller model for register access
// Assumes: Block takes one-cycle requests on the rising edge
// Notes:   Drives on the falling edge; idle bus shows inverted data
`timescale 1ns/1ps
module pxc_sta_model
(
    // Clock and read data
    input  wire logic               i_clk,
    input  wire logic        [15:0] i_rdata,
    // Management request
    output pxc_pkg::pxc_mgmt_t      o_mgmt
);
    import pxc_pkg::*;

    // Reserved bits 14:11, 4 and 1 default to zero
    localparam logic [15:0] RSVD_MASK = 16'h7812;
    int gap = 0;

    initial o_mgmt = '0;

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic wr(input logic [4:0] addr, input logic [15:0] data);
        repeat (gap) @(negedge i_clk);
        @(negedge i_clk);
        o_mgmt.addr  = addr;
        o_mgmt.wdata = data & ~RSVD_MASK;
        o_mgmt.wr    = 1'b1;
        @(negedge i_clk);
        o_mgmt.wr    = 1'b0;
        // Released bus must not look like the last word
        o_mgmt.wdata = ~o_mgmt.wdata;
        o_mgmt.addr  = ~addr;
    endtask : wr

    task automatic rd(input logic [4:0] addr, output logic [15:0] data);
        repeat (gap) @(negedge i_clk);
        @(negedge i_clk);
        o_mgmt.addr = addr;
        o_mgmt.rd   = 1'b1;
        @(negedge i_clk);
        o_mgmt.rd   = 1'b0;
        o_mgmt.addr = ~addr;
        // Registered read data, sampled one full cycle later
        @(negedge i_clk);
        data = i_rdata;
    endtask : rd
endmodule : pxc_sta_model
